// ===== design/nvm_cmd_regs.svh
`ifndef NVM_CMD_REGS_SVH
`define NVM_CMD_REGS_SVH

// Command object geometry
`define NVM_WORD_COUNT 6
`define NVM_IDX_FIRST_UNUSED 3'h6
`define NVM_IDX_LAST_UNUSED 3'h7
`define NVM_UNUSED_READ 16'h0000

// Field positions inside the command object
`define NVM_CODE_WORD 3'h0
`define NVM_ADDR_WORD 3'h1
`define NVM_CODE_MSB 15
`define NVM_CODE_LSB 8
`define NVM_ADDR_HI_MSB 1
`define NVM_ADDR_HI_LSB 0

// Reset values
`define NVM_FLAG_RESET 1'b1
`define NVM_WORD_RESET 16'h0000
`define NVM_INDEX_RESET 3'h0
`define NVM_DIV_RESET 6'h00

`endif

// ===== design/nvm_cmd_pkg.sv
package nvm_cmd_pkg;
   typedef logic [15:0] cmd_word_t;
   typedef logic [7:0] cmd_byte_t;
   typedef logic [2:0] word_index_t;
   typedef logic [5:0] clk_div_t;
   typedef logic [17:0] global_addr_t;
endpackage

// ===== design/nvm_op_clock_divider.sv
`include "nvm_cmd_regs.svh"

module nvm_op_clock_divider
(
   input wire logic clock,
   input wire logic reset,
   input wire logic divider_write,
   input wire nvm_cmd_pkg::clk_div_t divider_value,
   output nvm_cmd_pkg::clk_div_t nvm_clock_divider,
   output logic divider_loaded,
   output logic op_tick
);
   import nvm_cmd_pkg::*;

   clk_div_t count;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         nvm_clock_divider <= `NVM_DIV_RESET;
         divider_loaded <= 1'b0;
      end
      else if (divider_write)
      begin
         nvm_clock_divider <= divider_value;
         divider_loaded <= 1'b1;
      end
   end

   // Tick every divider+1 bus cycles; the resulting rate is never checked
   always_ff @(posedge clock)
   begin
      if (reset || divider_write || !divider_loaded)
      begin
         count <= `NVM_DIV_RESET;
         op_tick <= 1'b0;
      end
      else if (count == nvm_clock_divider)
      begin
         count <= `NVM_DIV_RESET;
         op_tick <= 1'b1;
      end
      else
      begin
         count <= count + 6'h01;
         op_tick <= 1'b0;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   a_divider_load: assert property (divider_write |=> divider_loaded && nvm_clock_divider == $past(divider_value))
      else $error("divider value not taken");
   a_tick_spacing: assert property (op_tick && nvm_clock_divider != 6'h00 && !divider_write |=> !op_tick)
      else $error("time base ticks back to back");
   a_tick_unloaded: assert property (!divider_loaded |=> !op_tick)
      else $error("tick before divider loaded");
endmodule

// ===== design/nvm_command_object_interface.sv
// Behaviour
// - Clearing the completion flag locks every command word until the controller sets the flag again.
// - Results are written into the array by the controller and are meant to be read once the flag is back at one.
// - Indices 6 and 7 hold no word, ignore writes and read as zero.
// - The upper byte of word 0 is the command code, the other words carry its parameters in order.
// - Word 0 low byte bits 1:0 and word 1 form the 18-bit global address, word 0 bits 7:2 are not used.
// - The program and erase time base is the bus clock divided by the programmed divider plus one.
// - The derived rate is not checked and never blocks an operation.
// - The array is six 16-bit words chosen by the index, each reachable as separate upper and lower bytes.
// - Software loads the words first, then writes a one to the flag to clear it and launch.
`include "nvm_cmd_regs.svh"

module nvm_command_object_interface
(
   input wire logic clock,
   input wire logic reset,
   input wire logic index_write,
   input wire nvm_cmd_pkg::word_index_t index_value,
   input wire logic write_upper,
   input wire logic write_lower,
   input wire nvm_cmd_pkg::cmd_byte_t write_byte,
   input wire logic flag_write,
   input wire logic flag_write_data,
   input wire logic divider_write,
   input wire nvm_cmd_pkg::clk_div_t divider_value,
   input wire logic ctrl_done,
   input wire logic ctrl_result_write,
   input wire nvm_cmd_pkg::word_index_t ctrl_result_index,
   input wire nvm_cmd_pkg::cmd_word_t ctrl_result_data,
   input wire nvm_cmd_pkg::word_index_t ctrl_read_index,
   output nvm_cmd_pkg::word_index_t command_word_index,
   output nvm_cmd_pkg::cmd_word_t read_word,
   output nvm_cmd_pkg::cmd_word_t ctrl_read_data,
   output logic command_complete_flag,
   output logic launch,
   output nvm_cmd_pkg::cmd_byte_t nvm_command_code,
   output nvm_cmd_pkg::global_addr_t global_address,
   output nvm_cmd_pkg::clk_div_t nvm_clock_divider,
   output logic divider_loaded,
   output logic op_tick
);
   import nvm_cmd_pkg::*;

   cmd_word_t command_object_array [`NVM_WORD_COUNT];
   logic launch_request;
   logic index_valid;

   assign launch_request = flag_write && flag_write_data && command_complete_flag;
   assign index_valid = command_word_index < `NVM_IDX_FIRST_UNUSED;

   // Index register stays writable while busy so results can be browsed
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         command_word_index <= `NVM_INDEX_RESET;
      end
      else if (index_write)
      begin
         command_word_index <= index_value;
      end
   end

   // Flag and launch pulse; clear only when idle, so done and clear never collide
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         command_complete_flag <= `NVM_FLAG_RESET;
         launch <= 1'b0;
      end
      else
      begin
         launch <= launch_request;
         if (launch_request)
         begin
            command_complete_flag <= 1'b0;
         end
         else if (!command_complete_flag && ctrl_done)
         begin
            command_complete_flag <= 1'b1;
         end
      end
   end

   // One storage word per entry with byte lanes
   generate
      for (genvar g = 0; g < `NVM_WORD_COUNT; g++)
      begin : g_word
         always_ff @(posedge clock)
         begin
            if (reset)
            begin
               command_object_array[g] <= `NVM_WORD_RESET;
            end
            else if (!command_complete_flag)
            begin
               if (ctrl_result_write && ctrl_result_index == 3'(g))
               begin
                  command_object_array[g] <= ctrl_result_data;
               end
            end
            else if (command_word_index == 3'(g))
            begin
               if (write_upper)
               begin
                  command_object_array[g][15:8] <= write_byte;
               end
               if (write_lower)
               begin
                  command_object_array[g][7:0] <= write_byte;
               end
            end
         end
      end
   endgenerate

   // Read paths registered to keep outputs glitch free, at one cycle of latency
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         read_word <= `NVM_UNUSED_READ;
      end
      else if (index_valid)
      begin
         read_word <= command_object_array[command_word_index];
      end
      else
      begin
         read_word <= `NVM_UNUSED_READ;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         ctrl_read_data <= `NVM_UNUSED_READ;
      end
      else if (ctrl_read_index < `NVM_IDX_FIRST_UNUSED)
      begin
         ctrl_read_data <= command_object_array[ctrl_read_index];
      end
      else
      begin
         ctrl_read_data <= `NVM_UNUSED_READ;
      end
   end

   // Decoded fields for the controller; bits 7:2 of word 0 are not used
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         nvm_command_code <= 8'h00;
         global_address <= 18'h00000;
      end
      else
      begin
         nvm_command_code <= command_object_array[`NVM_CODE_WORD][`NVM_CODE_MSB:`NVM_CODE_LSB];
         global_address <= {command_object_array[`NVM_CODE_WORD][`NVM_ADDR_HI_MSB:`NVM_ADDR_HI_LSB],
                            command_object_array[`NVM_ADDR_WORD]};
      end
   end

   nvm_op_clock_divider u_divider
   (
      .clock(clock),
      .reset(reset),
      .divider_write(divider_write),
      .divider_value(divider_value),
      .nvm_clock_divider(nvm_clock_divider),
      .divider_loaded(divider_loaded),
      .op_tick(op_tick)
   );

   // Helper view of the whole array for the checks below
   logic [16*`NVM_WORD_COUNT-1:0] array_flat;
   always_comb
   begin
      for (int i = 0; i < `NVM_WORD_COUNT; i++)
      begin
         array_flat[16*i +: 16] = command_object_array[i];
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   a_lock_while_busy: assert property (!command_complete_flag && !ctrl_result_write |=> $stable(array_flat))
      else $error("command words changed while busy");
   a_result_stored: assert property (!command_complete_flag && ctrl_result_write && ctrl_result_index < 3'h6
      |=> command_object_array[$past(ctrl_result_index)] == $past(ctrl_result_data))
      else $error("result word not stored");
   a_unused_reads_zero: assert property (command_word_index >= `NVM_IDX_FIRST_UNUSED
      && $stable(command_word_index) |=> read_word == `NVM_UNUSED_READ)
      else $error("unused index read not zero");
   a_unused_write_ignored: assert property (command_complete_flag && command_word_index >= 3'h6
      && !flag_write |=> $stable(array_flat))
      else $error("write to unused index changed storage");
   // Decode lags storage by one cycle, so only compare while storage held still
   a_code_follows_word: assert property ($stable(array_flat)
      |-> nvm_command_code == command_object_array[0][15:8]
      && global_address == {command_object_array[0][1:0], command_object_array[1]})
      else $error("code or address decode wrong");
   a_upper_lane: assert property (command_complete_flag && index_valid && write_upper && !write_lower
      && !launch_request |=> command_object_array[$past(command_word_index)] == {$past(write_byte),
      $past(command_object_array[command_word_index][7:0])})
      else $error("upper byte write wrong");
   a_launch_clears: assert property (launch_request |=> launch && !command_complete_flag ##1 !launch)
      else $error("launch did not clear flag");
   a_launch_ignored: assert property (flag_write && (!flag_write_data || !command_complete_flag) |=> !launch)
      else $error("launch from zero write or while busy");
   a_done_sets_flag: assert property (!command_complete_flag && ctrl_done |=> command_complete_flag)
      else $error("completion did not set flag");

   c_launch: cover property (launch);
   c_complete: cover property (!command_complete_flag && ctrl_done);
   c_unused_write: cover property (command_complete_flag && !index_valid && write_upper);
   c_result: cover property (!command_complete_flag && ctrl_result_write);
endmodule

// ===== test/nvm_ctrl_model.sv
module nvm_ctrl_model
(
   input wire logic clock,
   input wire logic reset,
   input wire logic launch,
   input wire logic slow,
   input wire nvm_cmd_pkg::cmd_word_t ctrl_read_data,
   output nvm_cmd_pkg::word_index_t ctrl_read_index,
   output logic ctrl_done,
   output logic ctrl_result_write,
   output nvm_cmd_pkg::word_index_t ctrl_result_index,
   output nvm_cmd_pkg::cmd_word_t ctrl_result_data
);
   timeunit 1ns;
   timeprecision 1ps;
   import nvm_cmd_pkg::*;
   logic [7:0] count;
   // Code word feeds the result
   assign ctrl_read_index = 3'h0;
   always_ff @(posedge clock)
   begin
      ctrl_done <= 1'b0;
      ctrl_result_write <= 1'b0;
      ctrl_result_index <= 3'h2;
      // Idle data keeps moving so a stale value never looks valid
      ctrl_result_data <= ~ctrl_result_data;
      if (reset)
      begin
         count <= 8'h00;
         ctrl_result_data <= 16'h0000;
      end
      else if (launch)
         count <= slow ? 8'h40 : 8'h03;
      else if (count != 8'h00)
      begin
         count <= count - 8'h01;
         // Result lands one cycle before done
         if (count == 8'h02)
         begin
            ctrl_result_write <= 1'b1;
            ctrl_result_data <= ~ctrl_read_data;
         end
         if (count == 8'h01)
            ctrl_done <= 1'b1;
      end
   end
endmodule

// ===== test/nvm_command_object_interface_tb_top.sv
module nvm_command_object_interface_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import nvm_cmd_pkg::*;
   logic clock = 0, reset = 1, index_write = 0, write_upper = 0, write_lower = 0;
   logic flag_write = 0, flag_write_data = 0, divider_write = 0, slow = 0;
   word_index_t index_value = 3'h0, command_word_index, ctrl_result_index, ctrl_read_index;
   cmd_byte_t write_byte = 8'h00, nvm_command_code;
   clk_div_t divider_value = 6'h00, nvm_clock_divider;
   cmd_word_t read_word, ctrl_read_data, ctrl_result_data;
   global_addr_t global_address;
   logic ctrl_done, ctrl_result_write, command_complete_flag, launch, divider_loaded, op_tick;
   int errors = 0, samples_checked = 0, n;
   always #2.5 clock = ~clock;
   nvm_command_object_interface dut
   (
      .clock(clock),
      .reset(reset),
      .index_write(index_write),
      .index_value(index_value),
      .write_upper(write_upper),
      .write_lower(write_lower),
      .write_byte(write_byte),
      .flag_write(flag_write),
      .flag_write_data(flag_write_data),
      .divider_write(divider_write),
      .divider_value(divider_value),
      .ctrl_done(ctrl_done),
      .ctrl_result_write(ctrl_result_write),
      .ctrl_result_index(ctrl_result_index),
      .ctrl_result_data(ctrl_result_data),
      .ctrl_read_index(ctrl_read_index),
      .command_word_index(command_word_index),
      .read_word(read_word),
      .ctrl_read_data(ctrl_read_data),
      .command_complete_flag(command_complete_flag),
      .launch(launch),
      .nvm_command_code(nvm_command_code),
      .global_address(global_address),
      .nvm_clock_divider(nvm_clock_divider),
      .divider_loaded(divider_loaded),
      .op_tick(op_tick)
   );
   nvm_ctrl_model partner
   (
      .clock(clock),
      .reset(reset),
      .launch(launch),
      .slow(slow),
      .ctrl_read_data(ctrl_read_data),
      .ctrl_read_index(ctrl_read_index),
      .ctrl_done(ctrl_done),
      .ctrl_result_write(ctrl_result_write),
      .ctrl_result_index(ctrl_result_index),
      .ctrl_result_data(ctrl_result_data)
   );
   task automatic tick(input int k = 1);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic put(input logic [2:0] i, input logic hi, input logic lo, input logic [7:0] b);
      index_write = 1;
      index_value = i;
      tick();
      index_write = 0;
      write_upper = hi;
      write_lower = lo;
      write_byte = b;
      tick();
      write_upper = 0;
      write_lower = 0;
      tick();
   endtask
   task automatic flag(input logic d);
      flag_write = 1;
      flag_write_data = d;
      tick();
      flag_write = 0;
   endtask
   task automatic div(input clk_div_t d);
      divider_value = d;
      divider_write = 1;
      tick();
      divider_write = 0;
      check("divider", d, nvm_clock_divider);
      check("loaded", 1, divider_loaded);
      for (n = 0; n < 70 && op_tick !== 1'b1; n++)
         tick();
      n = 0;
      do
      begin
         tick();
         n++;
      end while (op_tick !== 1'b1 && n < 70);
      check("tick gap", d + 1, n);
   endtask
   task automatic final_report;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #10000;
      errors++;
      final_report();
   end
   initial
   begin
      tick(8);
      reset = 0;
      check("flag", 1, command_complete_flag);
      check("loaded", 0, divider_loaded);
      put(0, 1, 0, 8'h0e);
      put(0, 0, 1, 8'h02);
      put(1, 1, 1, 8'h34);
      put(1, 0, 1, 8'h56);
      check("code", 8'h0e, nvm_command_code);
      check("address", 18'h23456, global_address);
      check("word1", 16'h3456, read_word);
      check("ctrl read", 16'h0e02, ctrl_read_data);
      for (int i = 6; i < 8; i++)
      begin
         put(i[2:0], 1, 1, 8'hff);
         check("unused", 0, read_word);
      end
      flag(0);
      check("launch", 0, launch);
      check("flag", 1, command_complete_flag);
      slow = 1;
      flag(1);
      check("launch", 1, launch);
      check("flag", 0, command_complete_flag);
      tick();
      check("launch", 0, launch);
      put(0, 1, 1, 8'hff);
      check("word0", 16'h0e02, read_word);
      flag(1);
      check("launch", 0, launch);
      for (n = 0; n < 100 && command_complete_flag !== 1'b1; n++)
         tick();
      check("flag", 1, command_complete_flag);
      put(2, 0, 0, 8'h00);
      check("index", 2, command_word_index);
      check("result", 16'hf1fd, read_word);
      div(6'h05);
      div(6'h3f);
      div(6'h00);
      // Divider 0 is out of range for real parts yet must not block
      slow = 0;
      flag(1);
      check("launch", 1, launch);
      for (n = 0; n < 10 && command_complete_flag !== 1'b1; n++)
         tick();
      check("flag", 1, command_complete_flag);
      final_report();
   end
endmodule
